// *** logic/scp_pkg.sv ***
// Overview of operation
// - three or four wire mode by select bit
// - three wire: data pin carries both directions
// - four wire: data pin in, output pin out
// - host data captured on rising serial clock
// - device launches output on falling clock
// - enable low for two to five bytes
// - instruction bit 7 high means read
// - bits 6:5 give data byte count minus one
// - bits 4:0 give starting register address
// - address decrements after each data byte
// - all bytes shifted msb first
// - instruction byte always driven by host
// - three wire read drives data pin only
// - four wire read drives output pin
// - four wire output pin low after last bit until enable rises, three wire releases data pin
// - status select routes indicator to output pin
// - four wire status select overrides read data
// - channel b offset split over two registers
// - all configuration registers readable and writable
// - rising update strobe copies offsets to working
package scp_pkg;
    localparam int          SCP_NUM_REGS    = 32;
    localparam logic [4:0]  SCP_ADDR_OFFA_H = 5'h0c;
    localparam logic [4:0]  SCP_ADDR_OFFA_L = 5'h0d;
    localparam logic [4:0]  SCP_ADDR_STSEL  = 5'h0e;
    localparam logic [4:0]  SCP_ADDR_OFFB_L = 5'h0f;
    localparam logic [4:0]  SCP_ADDR_MODE   = 5'h05;
    localparam int          SCP_FOUR_WIRE_BIT = 7;
    localparam int          SCP_STROBE_BIT  = 5;
    localparam logic [7:0]  SCP_REG_RESET   = 8'h00;
    localparam int          SCP_RNW_BIT     = 7;
    localparam int          SCP_CNT_HI      = 6;
    localparam int          SCP_CNT_LO      = 5;
    localparam logic [2:0]  SCP_SEL_SYNTH   = 3'h1;
    localparam logic [2:0]  SCP_SEL_DELAY   = 3'h2;
    localparam logic [2:0]  SCP_SEL_PATTERN = 3'h3;
    localparam logic [2:0]  SCP_SEL_BUFFER  = 3'h4;
    localparam logic [2:0]  SCP_SEL_SELFTEST = 3'h5;
    localparam int          SCP_CLK_DIV     = 20;
    localparam logic [7:0]  SCP_AXI_CMD     = 8'h00;
    localparam logic [7:0]  SCP_AXI_STAT    = 8'h04;
    localparam logic [7:0]  SCP_AXI_RDATA   = 8'h08;
    localparam logic [7:0]  SCP_AXI_WD      = 8'h0c;
    typedef enum logic [1:0] {
        SCP_IDLE = 2'b00,
        SCP_INST = 2'b01,
        SCP_DATA = 2'b11,
        SCP_DONE = 2'b10
    } scp_state_t;
endpackage : scp_pkg

// *** logic/scp_if.sv ***
`timescale 1ns/1ps
interface scp_if;
    logic serial_clock;
    logic serial_enable_n;
    logic host_data_o;
    logic host_data_oe;
    logic dev_data_o;
    logic dev_data_oe;
    logic serial_data_out_o;
    logic serial_data_out_oe;
    wire  serial_data_io_lvl = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 1'b1);
    modport device (
        input  serial_clock,
        input  serial_enable_n,
        input  serial_data_io_lvl,
        output dev_data_o,
        output dev_data_oe,
        output serial_data_out_o,
        output serial_data_out_oe
    );
    modport host (
        output serial_clock,
        output serial_enable_n,
        output host_data_o,
        output host_data_oe,
        input  serial_data_io_lvl,
        input  serial_data_out_o,
        input  serial_data_out_oe
    );
endinterface : scp_if

// *** logic/scp_device.sv ***
// Added by the designer: the AXI4-Lite slave port, which sits in scp_host; this module has none.
`timescale 1ns/1ps
module scp_device (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // serial link
    scp_if.device             link,
    // status indicators
    input  wire logic         synth_locked,
    input  wire logic         delay_loop_locked,
    input  wire logic         pattern_check_error,
    input  wire logic         input_buffer_error,
    input  wire logic         selftest_error,
    // working offsets and four wire select
    output logic [12:0]       channel_a_offset,
    output logic [12:0]       channel_b_offset,
    output logic              four_wire_select
);
    import scp_pkg::*;

    logic [2:0]  clk_s;
    logic [1:0]  en_s;
    logic [1:0]  din_s;
    logic [7:0]  regs [SCP_NUM_REGS];
    scp_state_t  state;
    logic [2:0]  bit_cnt;
    logic [1:0]  bytes_left;
    logic [7:0]  shift_in;
    logic [7:0]  shift_out;
    logic        rnw;
    logic [4:0]  addr;
    logic        strobe_q;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        enable_n;
    logic        dout;
    logic        drive_io;
    logic        drive_out;
    logic [7:0]  inst;
    logic [2:0]  sel;
    logic        status_bit;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_s <= 3'h0;
            en_s  <= 2'h3;
            din_s <= 2'h0;
        end else begin
            clk_s <= {clk_s[1:0], link.serial_clock};
            en_s  <= {en_s[0], link.serial_enable_n};
            din_s <= {din_s[0], link.serial_data_io_lvl};
        end
    end

    assign sclk_rise = clk_s[1] & ~clk_s[2];
    assign sclk_fall = ~clk_s[1] & clk_s[2];
    assign enable_n  = en_s[1];
    assign inst      = {shift_in[6:0], din_s[1]};
    assign four_wire_select = regs[SCP_ADDR_MODE][SCP_FOUR_WIRE_BIT];
    assign sel = regs[SCP_ADDR_STSEL][7:5];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= SCP_IDLE;
            bit_cnt    <= 3'h0;
            bytes_left <= 2'h0;
            shift_in   <= 8'h00;
            rnw        <= 1'b0;
            addr       <= 5'h00;
        end else if (enable_n) begin
            state   <= SCP_IDLE;
            bit_cnt <= 3'h0;
        end else if (sclk_rise && state != SCP_DONE) begin
            shift_in <= inst;
            bit_cnt  <= bit_cnt + 3'h1;
            if (state == SCP_IDLE) begin
                state <= SCP_INST;
            end
            if (bit_cnt == 3'h7) begin
                if (state != SCP_DATA) begin
                    rnw        <= inst[SCP_RNW_BIT];
                    bytes_left <= inst[SCP_CNT_HI:SCP_CNT_LO];
                    addr       <= inst[4:0];
                    state      <= SCP_DATA;
                end else begin
                    addr <= addr - 5'h1;
                    bytes_left <= bytes_left - 2'h1;
                    if (bytes_left == 2'h0) begin
                        state <= SCP_DONE;
                    end
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < SCP_NUM_REGS; i++) begin
                regs[i] <= SCP_REG_RESET;
            end
        end else if (!enable_n && sclk_rise && state == SCP_DATA && bit_cnt == 3'h7 && !rnw) begin
            regs[addr] <= inst;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strobe_q         <= 1'b0;
            channel_a_offset <= 13'h0000;
            channel_b_offset <= 13'h0000;
        end else begin
            strobe_q <= regs[SCP_ADDR_OFFA_H][SCP_STROBE_BIT];
            if (regs[SCP_ADDR_OFFA_H][SCP_STROBE_BIT] && !strobe_q) begin
                channel_a_offset <= {regs[SCP_ADDR_OFFA_H][4:0], regs[SCP_ADDR_OFFA_L]};
                channel_b_offset <= {regs[SCP_ADDR_STSEL][4:0], regs[SCP_ADDR_OFFB_L]};
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_out <= 8'h00;
            dout      <= 1'b0;
            drive_io  <= 1'b0;
            drive_out <= 1'b0;
        end else if (enable_n) begin
            drive_io  <= 1'b0;
            drive_out <= 1'b0;
            dout      <= 1'b0;
        end else if (sclk_fall) begin
            if (state == SCP_DATA && rnw) begin
                if (bit_cnt == 3'h0) begin
                    dout      <= regs[addr][7];
                    shift_out <= {regs[addr][6:0], 1'b0};
                end else begin
                    dout      <= shift_out[7];
                    shift_out <= {shift_out[6:0], 1'b0};
                end
                drive_io  <= ~four_wire_select;
                drive_out <= four_wire_select;
            end else if (state == SCP_DONE && rnw) begin
                dout     <= 1'b0;
                drive_io <= 1'b0;
            end
        end
    end

    always_comb begin
        case (sel)
            SCP_SEL_SYNTH:    status_bit = synth_locked;
            SCP_SEL_DELAY:    status_bit = delay_loop_locked;
            SCP_SEL_PATTERN:  status_bit = pattern_check_error;
            SCP_SEL_BUFFER:   status_bit = input_buffer_error;
            SCP_SEL_SELFTEST: status_bit = selftest_error;
            default:          status_bit = 1'b0;
        endcase
    end

    function automatic logic status_routed(input logic [2:0] s);
        return (s >= SCP_SEL_SYNTH) && (s <= SCP_SEL_SELFTEST);
    endfunction : status_routed

    // status selection overrides the output pin
    assign link.dev_data_o  = dout;
    assign link.dev_data_oe = drive_io;
    assign link.serial_data_out_o  = status_routed(sel) ? status_bit : dout;
    assign link.serial_data_out_oe = status_routed(sel) ? 1'b1 : drive_out;
endmodule : scp_device

// *** logic/scp_host.sv ***
`timescale 1ns/1ps
module scp_host (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // axi4-lite slave
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // serial link
    scp_if.host               link,
    input  wire logic         four_wire_mode
);
    import scp_pkg::*;

    logic        aw_hold;
    logic        w_hold;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [31:0] cmd;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        busy;
    logic        start;
    logic [5:0]  bits_total;
    logic [5:0]  bit_idx;
    logic [39:0] shift;
    logic [4:0]  div;
    logic        sclk;
    logic [1:0]  sdi_s;
    logic [1:0]  sdo_s;

    assign s_axi_awready = ~aw_hold;
    assign s_axi_wready  = ~w_hold;
    assign s_axi_arready = ~s_axi_rvalid;
    assign s_axi_bresp   = 2'b00;
    assign s_axi_rresp   = 2'b00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0;
            s_axi_bvalid <= 1'b0;
            cmd   <= 32'h0;
            wdat  <= 32'h0;
            start <= 1'b0;
        end else begin
            start <= 1'b0;
            if (s_axi_awvalid && !aw_hold) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (aw_hold && w_hold && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr == SCP_AXI_CMD && !busy) begin
                    cmd   <= w_data;
                    start <= 1'b1;
                end else if (aw_addr == SCP_AXI_WD) begin
                    wdat <= w_data;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold <= 1'b0;
                w_hold  <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                SCP_AXI_CMD:   s_axi_rdata <= cmd;
                SCP_AXI_STAT:  s_axi_rdata <= {31'h0, busy};
                SCP_AXI_RDATA: s_axi_rdata <= rdat;
                SCP_AXI_WD:    s_axi_rdata <= wdat;
                default:       s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdi_s <= 2'h0;
            sdo_s <= 2'h0;
        end else begin
            sdi_s <= {sdi_s[0], link.serial_data_io_lvl};
            sdo_s <= {sdo_s[0], link.serial_data_out_oe ? link.serial_data_out_o : 1'b1};
        end
    end

    // serial engine: frame is instruction plus 1..4 bytes, msb first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy  <= 1'b0;
            div   <= 5'h0;
            sclk  <= 1'b0;
            bit_idx    <= 6'h0;
            bits_total <= 6'h0;
            shift <= 40'h0;
            rdat  <= 32'h0;
        end else if (start) begin
            busy       <= 1'b1;
            div        <= 5'h0;
            sclk       <= 1'b0;
            bit_idx    <= 6'h0;
            bits_total <= 6'({cmd[6:5], 3'b000}) + 6'd16;
            shift      <= {cmd[7:0], wdat};
            rdat       <= 32'h0;
        end else if (busy) begin
            if (div == 5'(SCP_CLK_DIV - 1)) begin
                div  <= 5'h0;
                if (sclk) begin
                    sclk    <= 1'b0;
                    shift   <= {shift[38:0], 1'b0};
                    bit_idx <= bit_idx + 6'h1;
                end else if (bit_idx == bits_total) begin
                    busy <= 1'b0;
                end else begin
                    sclk <= 1'b1;
                    if (bit_idx >= 6'h08) begin
                        rdat <= {rdat[30:0], four_wire_mode ? sdo_s[1] : sdi_s[1]};
                    end
                end
            end else begin
                div <= div + 5'h1;
            end
        end
    end

    assign link.serial_clock    = sclk;
    assign link.serial_enable_n = ~busy;
    assign link.host_data_o     = shift[39];
    assign link.host_data_oe    = busy && (!cmd[7] || bit_idx < 6'd8 || four_wire_mode);
endmodule : scp_host

// *** verif/scp_monitor.sv ***
`timescale 1ns/1ps
module scp_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link signals
    input wire logic serial_clock,
    input wire logic serial_enable_n,
    input wire logic host_data_o,
    input wire logic host_data_oe,
    input wire logic dev_data_o,
    input wire logic dev_data_oe,
    input wire logic serial_data_out_o,
    input wire logic serial_data_out_oe,
    input wire logic serial_data_io_lvl
);
    logic       sclk_q;
    logic [5:0] rises;
    always_ff @(posedge aclk) begin
        sclk_q <= aresetn & serial_clock;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || serial_enable_n) begin
            rises <= 6'h00;
        end else if (serial_clock && !sclk_q) begin
            rises <= rises + 6'h01;
        end
    end
    default clocking mon_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    no_contention_a: assert property (!(dev_data_oe && host_data_oe))
        else $error("both ends drive the data pin");
    io_idle_release_a: assert property (serial_enable_n [*8] |-> !dev_data_oe)
        else $error("device drives data pin outside a frame");
    launch_on_fall_a: assert property (
        dev_data_oe && $changed(dev_data_o) && !serial_enable_n |-> !serial_clock)
        else $error("device output changed while serial clock high");
    out_pin_quiet_a: assert property (dev_data_oe |-> !serial_data_out_oe)
        else $error("output pin driven during three wire read");
    instr_by_host_a: assert property (
        $rose(serial_clock) && !serial_enable_n && rises < 6'd8
        |-> host_data_oe && serial_data_io_lvl == host_data_o)
        else $error("instruction bit not driven by host");
    capture_stable_a: assert property (
        $rose(serial_clock) && host_data_oe |-> $stable(host_data_o) ##1 $stable(host_data_o))
        else $error("host data moved at capture edge");
    frame_bytes_a: assert property (
        $rose(serial_enable_n) |-> rises inside {6'd16, 6'd24, 6'd32, 6'd40})
        else $error("frame not two to five whole bytes");
    clk_still_a: assert property ($changed(serial_clock) |-> !serial_enable_n)
        else $error("serial clock toggled outside a frame");
    cover property ($rose(serial_enable_n) && rises == 6'd40);
    cover property (dev_data_oe && !serial_enable_n);
    cover property (serial_data_out_oe && serial_data_out_o);
endmodule : scp_monitor

// *** verif/serial_config_port_bench.sv ***
`timescale 1ns/1ps
module serial_config_port_bench;
    import scp_pkg::*;
    typedef struct packed {logic [4:0] a; logic [1:0] n; logic [31:0] d;} scp_row_t;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, sh = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, fws;
    logic        four_wire_mode = 1'b0, sclk_q = 1'b0, io_used = 1'b0;
    logic        en_q = 1'b1, tail = 1'b0, io_clr = 1'b0;
    logic [4:0]  ind = 5'h00;
    logic [3:0]  nsh = 4'h0;
    logic [12:0] off_a, off_b, off_b2;
    int          err_total = 0, samples_checked = 0;
    scp_row_t    rows [4] = '{'{5'h01, 2'd0, 32'ha5000000}, '{5'h03, 2'd1, 32'h5a3c0000},
                              '{5'h0b, 2'd2, 32'hc3817e00}, '{5'h1f, 2'd3, 32'hdeadbeef}};
    scp_if link();
    scp_if lnk2();
    always #2.5 aclk = ~aclk;
    scp_host u_scp_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link.host),
        .four_wire_mode(four_wire_mode));
    scp_device u_scp_device (.aclk(aclk), .aresetn(aresetn), .link(link.device),
        .synth_locked(ind[0]), .delay_loop_locked(ind[1]), .pattern_check_error(ind[2]),
        .input_buffer_error(ind[3]), .selftest_error(ind[4]), .channel_a_offset(off_a),
        .channel_b_offset(off_b), .four_wire_select(fws));
    scp_device u_scp_device_b (.aclk(aclk), .aresetn(aresetn), .link(lnk2.device),
        .synth_locked(ind[0]), .delay_loop_locked(ind[1]), .pattern_check_error(ind[2]),
        .input_buffer_error(ind[3]), .selftest_error(ind[4]), .channel_a_offset(),
        .channel_b_offset(off_b2), .four_wire_select());
    scp_monitor u_scp_monitor (.aclk(aclk), .aresetn(aresetn),
        .serial_clock(link.serial_clock), .serial_enable_n(link.serial_enable_n),
        .host_data_o(link.host_data_o), .host_data_oe(link.host_data_oe),
        .dev_data_o(link.dev_data_o), .dev_data_oe(link.dev_data_oe),
        .serial_data_out_o(link.serial_data_out_o),
        .serial_data_out_oe(link.serial_data_out_oe),
        .serial_data_io_lvl(link.serial_data_io_lvl));
    // first byte seen on the data pin, and whether the device drove it
    always @(posedge aclk) begin
        sclk_q <= link.serial_clock;
        en_q   <= link.serial_enable_n;
        if (link.serial_enable_n && !en_q) tail <= link.serial_data_out_o;
        if (io_clr) io_used <= 1'b0;
        else if (link.dev_data_oe) io_used <= 1'b1;
        if (link.serial_enable_n) nsh <= 4'h0;
        else if (link.serial_clock && !sclk_q && nsh < 4'h8) begin
            sh  <= {sh[6:0], link.serial_data_io_lvl};
            nsh <= nsh + 4'h1;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh;
        ah = 1'b1;
        wh = 1'b1;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (ah || wh) begin
            @(posedge aclk);
            ah = ah && !awready;
            wh = wh && !wready;
            awvalid <= ah;
            wvalid  <= wh;
        end
        while (!bvalid) @(posedge aclk);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        d = rdata;
        rready <= 1'b0;
    endtask : rd
    task automatic xf(input logic [7:0] ins, input logic [31:0] d);
        logic [31:0] s;
        wr(SCP_AXI_WD, d);
        wr(SCP_AXI_CMD, {24'h0, ins});
        s = 32'h1;
        while (s[0]) rd(SCP_AXI_STAT, s);
        chk({24'h0, sh}, {24'h0, ins});
    endtask : xf
    task automatic rf(input logic [7:0] ins, output logic [31:0] d);
        xf(ins | 8'h80, 32'h0);
        rd(SCP_AXI_RDATA, d);
    endtask : rf
    // bench-driven frame on the second link, cut short when nb is not a byte multiple
    task automatic fr(input logic [39:0] v, input int nb);
        @(posedge aclk);
        lnk2.serial_enable_n <= 1'b0;
        lnk2.host_data_oe    <= 1'b1;
        for (int i = 0; i < nb; i++) begin
            repeat (13) @(posedge aclk);
            lnk2.serial_clock <= 1'b0;
            lnk2.host_data_o  <= v[39-i];
            repeat (12) @(posedge aclk);
            lnk2.serial_clock <= 1'b1;
        end
        repeat (13) @(posedge aclk);
        lnk2.serial_clock <= 1'b0;
        repeat (12) @(posedge aclk);
        lnk2.serial_enable_n <= 1'b1;
        lnk2.host_data_oe    <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : fr
    task automatic conclude;
        if (err_total == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (60000) @(posedge aclk);
        err_total++;
        $display("unexpected at %0t: timeout", $time);
        conclude();
    end
    initial begin
        logic [31:0] r;
        lnk2.serial_clock    = 1'b0;
        lnk2.serial_enable_n = 1'b1;
        lnk2.host_data_o     = 1'b0;
        lnk2.host_data_oe    = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rf(8'h2f, r);
        chk(r & 32'hffff, 32'h0);
        chk({6'h0, off_a, off_b}, 32'h0);
        rd(8'h10, r);
        chk(r, 32'h0);
        for (int m = 0; m < 2; m++) begin
            if (m == 1) begin
                xf({3'b000, SCP_ADDR_MODE}, 32'h80000000);
                four_wire_mode <= 1'b1;
                chk({31'h0, fws}, 32'h1);
            end
            io_clr <= 1'b1;
            @(posedge aclk);
            io_clr <= 1'b0;
            foreach (rows[i]) begin
                xf({1'b0, rows[i].n, rows[i].a}, rows[i].d);
                rf({1'b0, rows[i].n, rows[i].a}, r);
                chk(r & (32'hffffffff >> (8*(3-rows[i].n))), rows[i].d >> (8*(3-rows[i].n)));
                chk({31'h0, tail}, 32'h0);
            end
            chk({31'h0, io_used}, {31'h0, m == 0});
        end
        xf(8'h6f, 32'h34125620);
        chk({6'h0, off_a, off_b}, {6'h0, 13'h0056, 13'h1234});
        xf(8'h0f, 32'h99000000);
        chk({19'h0, off_b}, {19'h0, 13'h1234});
        rf(8'h0c, r);
        chk(r & 32'hff, 32'h20);
        for (int s = 1; s < 6; s++) begin
            xf(8'h0e, {s[2:0], 5'h12, 24'h0});
            for (int v = 0; v < 2; v++) begin
                ind <= v ? 5'h1 << (s - 1) : ~(5'h1 << (s - 1));
                repeat (4) @(posedge aclk);
                chk({30'h0, link.serial_data_out_oe, link.serial_data_out_o}, {30'h0, 1'b1, v[0]});
            end
        end
        ind <= 5'h1f;
        xf(8'h0e, 32'h72000000);
        rf(8'h01, r);
        chk(r & 32'hff, 32'hff);
        for (int k = 6; k < 8; k++) begin
            xf(8'h0e, {k[2:0], 5'h12, 24'h0});
            rf(8'h0e, r);
            chk(r & 32'hff, {24'h0, k[2:0], 5'h12});
        end
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn        <= 1'b1;
        four_wire_mode <= 1'b0;
        chk({6'h0, off_a, off_b}, 32'h0);
        chk({31'h0, fws}, 32'h0);
        rf(8'h0c, r);
        chk(r & 32'hff, 32'h0);
        fr(40'hffff000000, 5);
        fr({8'h6f, 8'h77, 8'h00, 8'h00, 8'h20}, 40);
        chk({19'h0, off_b2}, {19'h0, 13'h0077});
        conclude();
    end
endmodule : serial_config_port_bench
